// file: ecac_defines.svh
// Register offsets, bit positions, reset values and timing counts for the
// data EEPROM access controller.
// Assumes inclusion by bare name from the package and the controller.
`ifndef ECAC_DEFINES_SVH
`define ECAC_DEFINES_SVH

// Register index within the controller's I/O window
`define ECAC_OFS_ADDR_HIGH   2'h0
`define ECAC_OFS_ADDR_LOW    2'h1
`define ECAC_OFS_DATA_BYTE   2'h2
`define ECAC_OFS_CONTROL     2'h3

// Control register bit positions
`define ECAC_BIT_IRQ_EN      3
`define ECAC_BIT_WRITE_ARM   2
`define ECAC_BIT_WR_STROBE   1
`define ECAC_BIT_RD_STROBE   0

// Reset values
`define ECAC_RST_ADDR        9'h000
`define ECAC_RST_DATA        8'h00

// Timing counts in system clock cycles, except the write time
`define ECAC_ARM_CYCLES      3'h4
`define ECAC_READ_STALL      3'h4
`define ECAC_WRITE_STALL     3'h2
// Write time in calibrated 1 MHz oscillator cycles
`define ECAC_WRITE_TICKS     8448

`endif

// file: ecac_pkg.sv
// Types shared by the data EEPROM access controller and its users.
// Assumes the defines header is on the include path.
`include "ecac_defines.svh"

package ecac_pkg;

  // Request from the CPU I/O space into the controller
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [1:0] sel;
    logic [7:0] wdata;
  } ecac_io_req_s;

  // Array write engine states
  typedef enum logic [1:0] {
    ECAC_IDLE = 2'b01,
    ECAC_PROG = 2'b10
  } ecac_wr_state_e;

endpackage : ecac_pkg

// file: ecac_ctrl.sv
// CPU-side access controller for a 512-byte data EEPROM with its array.
// Assumes an I/O request that is valid for one cycle, synchronous to clk_sys,
// and a one-cycle oscTick pulse per period of the calibrated 1 MHz oscillator.
//
// Behaviour
// - 512 byte-wide locations, addressed linearly 0 to 511.
// - Address high byte holds bit 8; bits 15..9 read zero.
// - Data register supplies write byte and receives read byte.
// - Read trigger stalls the CPU for four cycles.
// - Write trigger stalls the CPU for two cycles.
// - Control bits 7..4 read zero.
// - Bit 3 enables ready interrupt, gated by global interrupt enable.
// - Ready interrupt is a level while write strobe reads zero; no flag.
// - Write starts only if strobe set within four cycles of arm.
// - Strobe with arm clear is ignored.
// - Hardware clears the arm bit four cycles after it is set.
// - Bit 1 write strobe, bit 0 read strobe; bits 3,2,0 reset zero.
// - Write is self-timed; strobe bit shows completion.
// - Hardware clears write strobe when the write finishes.
// - Read completes at once; byte ready in data register.
// - During a write, no array read and no address change.
// - Write lasts 8448 calibrated 1 MHz oscillator cycles.
`timescale 1ns/1ps
`include "ecac_defines.svh"

module ecac_ctrl #(
  parameter int unsigned WRITE_TICKS = `ECAC_WRITE_TICKS,
  parameter int unsigned DEPTH       = 512
) (
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 nrst,
  // CPU I/O access
  input  wire ecac_pkg::ecac_io_req_s ioReq,
  output logic [7:0]                ioRdData,
  output logic                      ioRdValid,
  // CPU status and stall
  input  wire logic                 globalIrqEnable,
  output logic                      cpuStall,
  output logic                      readyIrq,
  // Write timing source
  input  wire logic                 oscTick
);

  localparam int AW = $clog2(DEPTH);
  localparam int TW = $clog2(WRITE_TICKS + 1);

  //////////////////////////////////////////////////////////////////////////////
  // State

  logic [7:0]               nvmArray [DEPTH];
  logic [AW-1:0]            addrQ;
  logic [7:0]               dataQ;
  logic [7:0]               progByteQ;
  logic                     irqEnQ;
  logic [2:0]               armCntQ;
  logic [2:0]               stallCntQ;
  logic [TW-1:0]            tickCntQ;
  ecac_pkg::ecac_wr_state_e stateQ;
  ecac_pkg::ecac_wr_state_e stateD;
  logic [7:0]               rdDataQ;
  logic                     rdValidQ;

  //////////////////////////////////////////////////////////////////////////////
  // Decode

  function automatic logic selHit(input logic [1:0] sel, input logic [1:0] ofs);
    selHit = (sel == ofs);
  endfunction : selHit

  wire logic busy      = (stateQ == ecac_pkg::ECAC_PROG);
  wire logic armed     = (armCntQ != 3'h0);
  wire logic wrAddrHi  = ioReq.wr && selHit(ioReq.sel, `ECAC_OFS_ADDR_HIGH);
  wire logic wrAddrLo  = ioReq.wr && selHit(ioReq.sel, `ECAC_OFS_ADDR_LOW);
  wire logic wrData    = ioReq.wr && selHit(ioReq.sel, `ECAC_OFS_DATA_BYTE);
  wire logic wrCtrl    = ioReq.wr && selHit(ioReq.sel, `ECAC_OFS_CONTROL);
  wire logic armWr     = wrCtrl && ioReq.wdata[`ECAC_BIT_WRITE_ARM];
  wire logic strobeWr  = wrCtrl && ioReq.wdata[`ECAC_BIT_WR_STROBE];
  wire logic rdStrobe  = wrCtrl && ioReq.wdata[`ECAC_BIT_RD_STROBE];
  wire logic writeGo   = strobeWr && armed && !busy;
  wire logic readGo    = rdStrobe && !busy && !writeGo;
  wire logic lastTick  = busy && oscTick && (tickCntQ == TW'(1));

  //////////////////////////////////////////////////////////////////////////////
  // Write engine: idle until an armed strobe, then self-timed programming

  always_comb begin
    stateD = stateQ;
    unique case (stateQ)
      ecac_pkg::ECAC_IDLE: begin
        if (writeGo) begin
          stateD = ecac_pkg::ECAC_PROG;
        end
      end
      ecac_pkg::ECAC_PROG: begin
        if (lastTick) begin
          stateD = ecac_pkg::ECAC_IDLE;
        end
      end
      default: stateD = ecac_pkg::ECAC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stateQ <= ecac_pkg::ECAC_IDLE;
    end else begin
      stateQ <= stateD;
    end
  end

  // Oscillator tick down-counter for the write time
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tickCntQ <= '0;
    end else if (writeGo) begin
      tickCntQ <= TW'(WRITE_TICKS);
    end else if (busy && oscTick) begin
      tickCntQ <= tickCntQ - TW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Arm window: reloads on every arm write, lapses after four cycles

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      armCntQ <= 3'h0;
    end else if (armWr) begin
      armCntQ <= `ECAC_ARM_CYCLES;
    end else if (armed) begin
      armCntQ <= armCntQ - 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Address, data and interrupt enable registers

  // Address is frozen while programming; only bit 8 of the high byte stores
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      addrQ <= AW'(`ECAC_RST_ADDR);
    end else if (!busy && wrAddrHi) begin
      addrQ <= {ioReq.wdata[AW-9:0], addrQ[7:0]};
    end else if (!busy && wrAddrLo) begin
      addrQ <= {addrQ[AW-1:8], ioReq.wdata};
    end
  end

  // Data register takes software writes and array reads
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dataQ <= `ECAC_RST_DATA;
    end else if (readGo) begin
      dataQ <= nvmArray[addrQ];
    end else if (wrData) begin
      dataQ <= ioReq.wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqEnQ <= 1'b0;
    end else if (wrCtrl) begin
      irqEnQ <= ioReq.wdata[`ECAC_BIT_IRQ_EN];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Array: byte captured at start, committed when the write time ends

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      progByteQ <= 8'h00;
    end else if (writeGo) begin
      progByteQ <= dataQ;
    end
  end

  // Nonvolatile contents are not reset
  always_ff @(posedge clk_sys) begin
    if (lastTick) begin
      nvmArray[addrQ] <= progByteQ;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // CPU stall after a triggered access

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stallCntQ <= 3'h0;
    end else if (readGo) begin
      stallCntQ <= `ECAC_READ_STALL;
    end else if (writeGo) begin
      stallCntQ <= `ECAC_WRITE_STALL;
    end else if (stallCntQ != 3'h0) begin
      stallCntQ <= stallCntQ - 3'h1;
    end
  end

  assign cpuStall = (stallCntQ != 3'h0);

  // Level request while no write is running; no latched flag
  assign readyIrq = irqEnQ && globalIrqEnable && !busy;

  //////////////////////////////////////////////////////////////////////////////
  // Register read-back, one cycle after the request

  wire logic [7:0] ctrlView = {4'h0, irqEnQ, armed, busy, 1'b0};
  wire logic [7:0] hiView   = {{(16 - AW){1'b0}}, addrQ[AW-1:8]};
  wire logic [7:0] rdMux    = selHit(ioReq.sel, `ECAC_OFS_ADDR_HIGH) ? hiView :
                              selHit(ioReq.sel, `ECAC_OFS_ADDR_LOW)  ? addrQ[7:0] :
                              selHit(ioReq.sel, `ECAC_OFS_DATA_BYTE) ? dataQ :
                              ctrlView;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdDataQ  <= 8'h00;
      rdValidQ <= 1'b0;
    end else begin
      rdValidQ <= ioReq.rd;
      if (ioReq.rd) begin
        rdDataQ <= rdMux;
      end
    end
  end

  assign ioRdData  = rdDataQ;
  assign ioRdValid = rdValidQ;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  AST_ADDR_HI_ZERO: assert property (
    ioReq.rd && selHit(ioReq.sel, `ECAC_OFS_ADDR_HIGH) |=> ioRdData[7:1] == 7'h00)
    else $error("address high reserved bits not zero");

  AST_CTRL_RSVD: assert property (
    ioReq.rd && selHit(ioReq.sel, `ECAC_OFS_CONTROL) |=> ioRdData[7:4] == 4'h0 && !ioRdData[0])
    else $error("control reserved bits not zero");

  AST_READ_STALL: assert property (
    readGo |=> cpuStall[*4] ##1 !cpuStall)
    else $error("read stall not four cycles");

  AST_WRITE_STALL: assert property (
    writeGo |=> cpuStall[*2] ##1 !cpuStall)
    else $error("write stall not two cycles");

  AST_ARM_LAPSE: assert property (
    $rose(armed) && !armWr ##1 (!armWr)[*3] |-> ##1 !armed)
    else $error("arm bit not cleared after four cycles");

  AST_UNARMED_IGNORED: assert property (
    strobeWr && !armed && !busy |=> !busy)
    else $error("unarmed strobe started a write");

  AST_ARMED_STARTS: assert property (
    strobeWr && armed && !busy |=> busy ##0 ctrlView[`ECAC_BIT_WR_STROBE])
    else $error("armed strobe did not start a write");

  AST_IRQ_BUSY: assert property (
    busy |-> !readyIrq)
    else $error("ready interrupt during write");

  AST_IRQ_READY: assert property (
    irqEnQ && globalIrqEnable && $fell(busy) |-> readyIrq)
    else $error("ready interrupt missing after write");

  AST_ADDR_HOLD: assert property (
    busy && $past(busy) |-> $stable(addrQ))
    else $error("address changed during write");

  AST_NO_READ_BUSY: assert property (
    busy |-> !readGo ##1 !($rose(cpuStall) && stallCntQ == `ECAC_READ_STALL))
    else $error("array read during write");

  AST_DONE_ON_TICK: assert property (
    $fell(busy) |-> $past(oscTick) && $past(tickCntQ) == TW'(1))
    else $error("write ended without final tick");

  AST_READ_BLOCKED: assert property (
    busy && rdStrobe |=> $stable(dataQ) && !$rose(cpuStall))
    else $error("read strobe acted during write");

  AST_TICK_LOAD: assert property (
    writeGo |=> tickCntQ == TW'(WRITE_TICKS))
    else $error("write time not loaded at start");

  AST_PROG_BYTE: assert property (
    writeGo |=> progByteQ == $past(dataQ))
    else $error("programmed byte differs from data register");

  AST_IRQ_GATED: assert property (
    !(irqEnQ && globalIrqEnable) |-> !readyIrq)
    else $error("ready interrupt without both enables");

endmodule : ecac_ctrl

// file: ecac_cpu_model.sv
// CPU core model that issues I/O register accesses to the EEPROM controller.
// Assumes requests are sampled on the rising clk_sys edge and changed on the falling one.
`timescale 1ns/1ps
`include "ecac_defines.svh"

module ecac_cpu_model (
  // Clock and controller answers
  input  wire logic              clk_sys,
  input  wire logic              cpuStall,
  input  wire logic [7:0]        ioRdData,
  input  wire logic              ioRdValid,
  // Requests and status towards the controller
  output ecac_pkg::ecac_io_req_s ioReq,
  output logic                   globalIrqEnable
);
  ////////////////////////////////////////////////////////////////////////////
  // Idle bus at time zero
  initial begin
    ioReq = '0;
    globalIrqEnable = 1'b0;
  end

  // One register write; the core waits out any stall first
  task automatic wrReg(input logic [1:0] sel, input logic [7:0] val);
    @(negedge clk_sys);
    while (cpuStall === 1'b1) @(negedge clk_sys);
    ioReq = {1'b1, 1'b0, sel, val};
    @(negedge clk_sys);
    ioReq = '0;
  endtask : wrReg

  // One register read; data only counts while the valid pulse is up
  task automatic rdReg(input logic [1:0] sel, output logic [7:0] val);
    @(negedge clk_sys);
    while (cpuStall === 1'b1) @(negedge clk_sys);
    ioReq = {1'b0, 1'b1, sel, 8'h00};
    @(negedge clk_sys);
    ioReq = '0;
    val = (ioRdValid === 1'b1) ? ioRdData : 8'hxx;
  endtask : rdReg

  // Load a full address before any access
  task automatic setAddr(input logic [8:0] a);
    wrReg(`ECAC_OFS_ADDR_HIGH, {7'h00, a[8]});
    wrReg(`ECAC_OFS_ADDR_LOW, a[7:0]);
  endtask : setAddr

  // Guarded write: arm, then strobe inside the window
  task automatic startWrite(input logic ien);
    wrReg(`ECAC_OFS_CONTROL, {4'h0, ien, 3'h4});
    wrReg(`ECAC_OFS_CONTROL, {4'h0, ien, 3'h2});
  endtask : startWrite

  // Global interrupt enable of the core status
  task automatic setGie(input logic b);
    globalIrqEnable = b;
  endtask : setGie
endmodule : ecac_cpu_model

// file: eeprom_cpu_access_controller_test.sv
// Self-checking testbench for the EEPROM access controller.
// Assumes the CPU model drives all requests; the bench makes clock, reset and ticks.
`timescale 1ns/1ps
`include "ecac_defines.svh"

module eeprom_cpu_access_controller_test;
  localparam int TICKS = 4;
  localparam int TPER  = 10;
  localparam logic [1:0] SH = `ECAC_OFS_ADDR_HIGH;
  localparam logic [1:0] SL = `ECAC_OFS_ADDR_LOW;
  localparam logic [1:0] SD = `ECAC_OFS_DATA_BYTE;
  localparam logic [1:0] SC = `ECAC_OFS_CONTROL;
  logic                   clk_sys = 1'b0;
  logic                   nrst    = 1'b0;
  logic                   oscTick = 1'b0;
  ecac_pkg::ecac_io_req_s ioReq;
  logic [7:0]             ioRdData;
  logic                   ioRdValid, globalIrqEnable, cpuStall, readyIrq;
  int                     num_errors = 0;
  int                     n_compared = 0;
  int                     tickCnt = 0;
  int                     n;
  time                    t0;
  logic [7:0]             rv;
  logic [8:0]             ad [3] = '{9'h000, 9'h1ff, 9'h0a5};
  logic [7:0]             dt [3] = '{8'h3c, 8'hc3, 8'h5a};

  ////////////////////////////////////////////////////////////////////////////
  // Design and CPU model
  ecac_ctrl #(.WRITE_TICKS(TICKS)) DUT (.clk_sys(clk_sys), .nrst(nrst), .ioReq(ioReq),
    .ioRdData(ioRdData), .ioRdValid(ioRdValid), .globalIrqEnable(globalIrqEnable),
    .cpuStall(cpuStall), .readyIrq(readyIrq), .oscTick(oscTick));
  ecac_cpu_model cpu (.clk_sys(clk_sys), .cpuStall(cpuStall), .ioRdData(ioRdData),
    .ioRdValid(ioRdValid), .ioReq(ioReq), .globalIrqEnable(globalIrqEnable));

  // Clock and a one-cycle oscillator tick every TPER cycles
  always #5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    tickCnt <= (tickCnt == TPER - 1) ? 0 : tickCnt + 1;
    oscTick <= (tickCnt == TPER - 1);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and helpers
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic finish_test;
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  task automatic rdChk(input logic [1:0] sel, input logic [7:0] exp);
    logic [7:0] v;
    cpu.rdReg(sel, v);
    chk(v, exp);
  endtask : rdChk

  // Count stalled cycles over the next eight
  task automatic stalls(output int cnt);
    cnt = 0;
    for (int i = 0; i < 8; i++) begin
      if (cpuStall === 1'b1) cnt++;
      @(negedge clk_sys);
    end
  endtask : stalls

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(negedge clk_sys);
    nrst = 1'b1;
    rdChk(SH, 8'h00);
    rdChk(SD, 8'h00);
    rdChk(SC, 8'h00);
    cpu.wrReg(SH, 8'hff);
    cpu.wrReg(SC, 8'hf0);
    rdChk(SH, 8'h01);
    rdChk(SC, 8'h00);
    cpu.wrReg(SC, 8'h02);
    rdChk(SC, 8'h00);
    cpu.wrReg(SC, 8'h04);
    rdChk(SC, 8'h04);
    repeat (1) @(negedge clk_sys);
    cpu.wrReg(SC, 8'h02);
    rdChk(SC, 8'h00);
    cpu.wrReg(SC, 8'h08);
    cpu.setGie(1'b1);
    @(negedge clk_sys);
    chk({7'h00, readyIrq}, 8'h01);
    cpu.setGie(1'b0);
    @(negedge clk_sys);
    chk({7'h00, readyIrq}, 8'h00);
    cpu.setGie(1'b1);
    // Write three bytes, corners of the array among them
    for (int k = 0; k < 3; k++) begin
      cpu.setAddr(ad[k]);
      cpu.wrReg(SD, dt[k]);
      cpu.startWrite(1'b1);
      t0 = $time;
      stalls(n);
      chk(8'(n), 8'h02);
      chk({7'h00, readyIrq}, 8'h00);
      rdChk(SC, 8'h0a);
      cpu.setAddr(~ad[k]);
      cpu.wrReg(SC, 8'h09);
      stalls(n);
      chk(8'(n), 8'h00);
      rv = 8'h02;
      while (rv[1] === 1'b1 && $time - t0 < 1000) cpu.rdReg(SC, rv);
      n = int'(($time - t0) / 10);
      chk({7'h00, n >= (TICKS - 1) * TPER && n <= (TICKS + 1) * TPER + 4}, 8'h01);
      chk({7'h00, readyIrq}, 8'h01);
      rdChk(SL, ad[k][7:0]);
    end
    // Read the bytes back
    for (int k = 0; k < 3; k++) begin
      cpu.setAddr(ad[k]);
      cpu.wrReg(SC, 8'h01);
      stalls(n);
      chk(8'(n), 8'h04);
      chk({7'h00, readyIrq}, 8'h00);
      rdChk(SD, dt[k]);
    end
    finish_test();
  end
endmodule : eeprom_cpu_access_controller_test
